//--- pkg/odc_pkg.sv
// Package with constants, types and register map of the operating definition command block
package odc_pkg;
  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_CHG_DEF = 8'h40;
  localparam logic [7:0] OPC_COMPARE = 8'h39;
  localparam logic [7:0] OPC_COPY = 8'h18;
  localparam logic [7:0] OPC_INQUIRY = 8'h12;
  localparam logic [7:0] OPC_REQ_SENSE = 8'h03;
  localparam logic [7:0] OPC_TEST_READY = 8'h00;
  // ----------------------------------------------------------------
  // Definition parameter values
  // ----------------------------------------------------------------
  localparam logic [6:0] DEF_KEEP = 7'h00;
  localparam logic [6:0] DEF_GEN1 = 7'h01;
  localparam logic [6:0] DEF_COMMON_COMMAND_SET_PROFILE = 7'h02;
  localparam logic [6:0] DEF_GEN2 = 7'h03;
  localparam logic [6:0] DEF_RSVD_LO = 7'h04;
  localparam logic [6:0] DEF_VENDOR_LO = 7'h40;
  localparam logic [6:0] DEF_DEFAULT = DEF_GEN2;
  // ----------------------------------------------------------------
  // Register byte addresses and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CDB0 = 8'h00;
  localparam logic [7:0] ADDR_CDB1 = 8'h04;
  localparam logic [7:0] ADDR_CDB2 = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_PDATA = 8'h14;
  localparam logic [7:0] ADDR_SEL = 8'h18;
  localparam logic [7:0] ADDR_DEF = 8'h1C;
  localparam logic [7:0] ADDR_UA = 8'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [2:0] LUN_ZERO = 3'h0;
  localparam int LUNS = 8;
  localparam int UNITS = 64;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_PARAM = 2'b01, ST_ACK = 2'b10} odc_state_t;
  typedef enum logic [2:0] {
    OC_NONE = 3'b000, OC_CHG = 3'b001, OC_CMP = 3'b010, OC_COPY = 3'b011,
    OC_INQ = 3'b100, OC_SENSE = 3'b101, OC_DIAG = 3'b110, OC_TUR = 3'b111
  } odc_opclass_t;
  typedef enum logic [1:0] {
    SC_LUN_INIT = 2'b00, SC_TGT_INIT = 2'b01, SC_LUN_ALL = 2'b10, SC_TGT_ALL = 2'b11
  } odc_scope_t;
  typedef struct packed {logic [2:0] lun; logic [4:0] rsvd;} odc_b1_t;
  typedef struct packed {logic [6:0] rsvd; logic save;} odc_b2_t;
  typedef struct packed {logic rsvd; logic [6:0] defp;} odc_b3_t;
  typedef struct packed {
    logic [7:0] ctrl; logic [7:0] len; logic [31:0] rsvd; odc_b3_t b3; odc_b2_t b2; odc_b1_t b1; logic [7:0] opc;
  } odc_cdb_t;
  typedef struct packed {
    logic [21:0] rsvd2; logic lost; logic abort; logic rsvd1; logic [2:0] init; logic [2:0] rsvd0; logic start;
  } odc_ctrl_t;
  typedef struct packed {
    logic [21:0] rsvd2; odc_scope_t scope; logic rsvd1; logic [2:0] init; logic rsvd0; logic [2:0] lun;
  } odc_sel_t;
  typedef struct packed {
    logic [4:0] rsvd; logic ext_recovery_ok; logic sense_len4; logic async_event_notice_ok; logic legacy;
    logic [6:0] cur_def; logic [7:0] remaining; logic ack_wait; logic param_wait; odc_opclass_t opclass;
    logic good; logic check; logic busy;
  } odc_status_t;
  typedef struct packed {logic [2:0] lun; logic save; logic [6:0] defp; logic [7:0] len;} odc_cmd_t;
endpackage : odc_pkg

//--- hdl/odc_top.sv
// Operating definition command logic of the target, with an AXI4-Lite register slave
// How it works
// R1 - Decode the common opcodes: change definition, compare and copy.
// R2 - Mandatory common commands such as inquiry are recognised; optional ones may be refused.
// R3 - Ten-byte descriptor: opcode, unit number, persist flag, definition, length, control.
// R4 - Persist flag one writes the new definition out to non-volatile storage.
// R5 - Definition 00h keeps, 01h first generation, 02h command set profile, 03h second generation.
// R6 - Values 04h-3Fh reserved, 40h-7Fh vendor specific.
// R7 - Zero parameter length moves no data and is no error.
// R8 - Non-zero length: initiator sends exactly that many parameter bytes.
// R9 - Definitions kept per unit per initiator, per target per initiator, per unit, or one.
// R10 - New definition applied only when ACK of command complete is seen.
// R11 - A change raises unit attention toward every affected initiator.
// R12 - A failed command leaves the definition exactly as before.
// R13 - Failed restore of the previous definition raises unit attention.
// R14 - After power-on or hard reset load the saved definition or the default.
// R15 - Under first-generation behaviour the change command is still accepted.
// R16 - Legacy definition: no async event notices and no probing for them.
// R17 - Legacy definition: no extended contingent allegiance via initiate recovery.
// R18 - Legacy definition: request sense with zero allocation returns four bytes.
// R19 - Legacy definition: inquiry version fields match and feature bits clear.
// R20 - Initiator should confirm a change with an inquiry of the definition page.
// R21 - Inquiry, request sense, send diagnostic and test unit ready are implemented.
// R22 - Unit attention stays pending per unit per initiator until that initiator clears it.
// R23 - Reserved or vendor definition ends with check condition, definition unchanged.
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module odc_top #(
  parameter logic [7:0] OPC_SEND_DIAG = 8'h1D,
  parameter bit SAVE_IMPL = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Bus pins
  input wire logic cc_ack,
  input wire logic bus_hard_rst,
  // Non-volatile storage
  input wire logic [6:0] nv_saved_def,
  output logic nv_save,
  output logic [6:0] nv_save_def,
  // Policy
  output logic async_event_notice_en
);
  import odc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff, wdata_ff, cdb0_ff, cdb1_ff;
  logic [15:0] cdb2_ff;
  logic [3:0] wstrb_ff;
  logic [7:0] awaddr_ff, remaining_ff;
  logic aw_held_ff, w_held_ff;
  logic ack_s1_ff, ack_s2_ff, ack_prev_ff, hrst_s1_ff, hrst_s2_ff, hrst_prev_ff;
  logic init_pend_ff, check_ff, good_ff, nv_save_ff, aen_en_ff;
  logic [6:0] nv_save_def_ff;
  logic [6:0] def_mem_ff [UNITS];
  logic [UNITS-1:0] ua_ff;
  logic [2:0] cur_init_ff;
  odc_sel_t sel_ff;
  odc_cmd_t cmd_ff;
  odc_opclass_t opclass_ff, nxt_opclass;
  odc_state_t state_ff;
  odc_cdb_t cdb;
  odc_ctrl_t ctrl_w;
  odc_status_t status;
  logic do_wr, wr_hit, rd_hit, wr_cdb0, wr_cdb1, wr_cdb2, wr_ctrl, wr_pdata, wr_sel, wr_ua;
  logic start, abort, lost, ack_rise, hrst_rise, apply, def_bad;
  logic [31:0] rd_word;
  logic [5:0] cmd_idx, sel_idx;
  logic [6:0] sel_def;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge for plain storage registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Units touched by a change at the current scope
  function automatic logic scope_hit(input logic [5:0] k, input logic [5:0] c, input odc_scope_t sc);
    logic res;
    res = 1'b0;
    case (sc)
      SC_LUN_INIT: res = (k == c);
      SC_TGT_INIT: res = (k[5:3] == c[5:3]);
      SC_LUN_ALL: res = (k[2:0] == c[2:0]);
      default: res = 1'b1;
    endcase
    return res;
  endfunction : scope_hit

  function automatic logic is_legacy(input logic [6:0] d);
    return (d == DEF_GEN1) || (d == DEF_COMMON_COMMAND_SET_PROFILE);
  endfunction : is_legacy

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two stages before use; edge detection looks only at the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
      ack_prev_ff <= 1'b0;
      hrst_s1_ff <= 1'b0;
      hrst_s2_ff <= 1'b0;
      hrst_prev_ff <= 1'b0;
    end else begin
      ack_s1_ff <= cc_ack;
      ack_s2_ff <= ack_s1_ff;
      ack_prev_ff <= ack_s2_ff;
      hrst_s1_ff <= bus_hard_rst;
      hrst_s2_ff <= hrst_s1_ff;
      hrst_prev_ff <= hrst_s2_ff;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign cdb = odc_cdb_t'({cdb2_ff, cdb1_ff, cdb0_ff}); // R3
  assign ctrl_w = odc_ctrl_t'(wdata_ff);
  assign ack_rise = ack_s2_ff && !ack_prev_ff;
  assign hrst_rise = hrst_s2_ff && !hrst_prev_ff;
  assign do_wr = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_cdb0 = do_wr && (awaddr_ff == ADDR_CDB0);
  assign wr_cdb1 = do_wr && (awaddr_ff == ADDR_CDB1);
  assign wr_cdb2 = do_wr && (awaddr_ff == ADDR_CDB2);
  assign wr_ctrl = do_wr && (awaddr_ff == ADDR_CTRL) && wstrb_ff[0];
  assign wr_pdata = do_wr && (awaddr_ff == ADDR_PDATA) && wstrb_ff[0];
  assign wr_sel = do_wr && (awaddr_ff == ADDR_SEL);
  assign wr_ua = do_wr && (awaddr_ff == ADDR_UA) && wstrb_ff[0];
  // Start is accepted whatever the current definition, so a legacy unit can be switched back
  assign start = wr_ctrl && ctrl_w.start && (state_ff == ST_IDLE); // R15
  assign abort = wr_ctrl && ctrl_w.abort;
  assign lost = wr_ctrl && ctrl_w.lost;
  assign def_bad = (cdb.b3.defp >= DEF_RSVD_LO); // R6
  assign apply = (state_ff == ST_ACK) && ack_rise && !abort && !hrst_rise; // R10
  assign cmd_idx = {cur_init_ff, cmd_ff.lun};
  assign sel_idx = {sel_ff.init, sel_ff.lun};
  assign sel_def = def_mem_ff[sel_idx];

  // Opcode classification
  always_comb begin
    if (cdb.opc == OPC_CHG_DEF) begin
      nxt_opclass = OC_CHG; // R1
    end else if (cdb.opc == OPC_COMPARE) begin
      nxt_opclass = OC_CMP; // R1
    end else if (cdb.opc == OPC_COPY) begin
      nxt_opclass = OC_COPY; // R1
    end else if (cdb.opc == OPC_INQUIRY) begin
      nxt_opclass = OC_INQ; // R2
    end else if (cdb.opc == OPC_REQ_SENSE) begin
      nxt_opclass = OC_SENSE; // R21
    end else if (cdb.opc == OPC_SEND_DIAG) begin
      nxt_opclass = OC_DIAG; // R21
    end else if (cdb.opc == OPC_TEST_READY) begin
      nxt_opclass = OC_TUR; // R21
    end else begin
      nxt_opclass = OC_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  // Compare and copy are optional and not carried out here, so they end in check condition
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      cmd_ff <= '0;
      cur_init_ff <= '0;
      opclass_ff <= OC_NONE;
      remaining_ff <= '0;
      check_ff <= 1'b0;
      good_ff <= 1'b0;
    end else if (hrst_rise) begin
      state_ff <= ST_IDLE;
      remaining_ff <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            cur_init_ff <= ctrl_w.init;
            cmd_ff <= {cdb.b1.lun, cdb.b2.save, cdb.b3.defp, cdb.len};
            opclass_ff <= nxt_opclass;
            check_ff <= 1'b0;
            good_ff <= 1'b0;
            if (nxt_opclass == OC_CHG) begin
              if (def_bad) begin
                check_ff <= 1'b1; // R23
              end else if (cdb.len == '0) begin
                state_ff <= ST_ACK; // R7
              end else begin
                state_ff <= ST_PARAM; // R8
                remaining_ff <= cdb.len;
              end
            end else if ((nxt_opclass == OC_NONE) || (nxt_opclass == OC_CMP) || (nxt_opclass == OC_COPY)) begin
              check_ff <= 1'b1; // R2
            end else begin
              good_ff <= 1'b1; // R2
            end
          end
        end
        ST_PARAM: begin
          if (abort) begin
            state_ff <= ST_IDLE; // R12
            check_ff <= 1'b1;
          end else if (wr_pdata) begin
            remaining_ff <= remaining_ff - 8'h01;
            if (remaining_ff == 8'h01) begin
              state_ff <= ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (abort) begin
            state_ff <= ST_IDLE; // R12
            check_ff <= 1'b1;
          end else if (apply) begin
            state_ff <= ST_IDLE;
            good_ff <= 1'b1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Definition store and unit attention
  // ----------------------------------------------------------------
  // Reset writes a constant; the saved value is loaded one edge after release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      init_pend_ff <= 1'b1;
    end else begin
      init_pend_ff <= hrst_rise;
    end
  end

  // One entry per unit per initiator covers all four scopes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int k = 0; k < UNITS; k++) begin
        def_mem_ff[k] <= DEF_DEFAULT;
      end
    end else begin
      for (int k = 0; k < UNITS; k++) begin
        if (init_pend_ff) begin
          def_mem_ff[k] <= SAVE_IMPL ? nv_saved_def : DEF_DEFAULT; // R14
        end else if (apply && (cmd_ff.defp != DEF_KEEP) && scope_hit(6'(k), cmd_idx, sel_ff.scope)) begin
          def_mem_ff[k] <= cmd_ff.defp; // R9
        end
      end
    end
  end

  // Set beats a clear in the same cycle, so no attention is lost
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ua_ff <= '0;
    end else begin
      for (int k = 0; k < UNITS; k++) begin
        if (((apply && (cmd_ff.defp != DEF_KEEP)) || lost) && scope_hit(6'(k), cmd_idx, sel_ff.scope)) begin
          ua_ff[k] <= 1'b1; // R11 R13
        end else if (wr_ua && (k[5:3] == sel_ff.init) && wdata_ff[k[2:0]]) begin
          ua_ff[k] <= 1'b0; // R22
        end
      end
    end
  end

  // Save request and legacy policy outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nv_save_ff <= 1'b0;
      nv_save_def_ff <= DEF_DEFAULT;
      aen_en_ff <= 1'b0;
    end else begin
      nv_save_ff <= apply && cmd_ff.save; // R4
      if (apply && cmd_ff.save) begin
        nv_save_def_ff <= (cmd_ff.defp == DEF_KEEP) ? def_mem_ff[cmd_idx] : cmd_ff.defp; // R4 R5
      end
      aen_en_ff <= !is_legacy(sel_def); // R16
    end
  end

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  assign status = '{rsvd: '0, ext_recovery_ok: !is_legacy(sel_def), sense_len4: is_legacy(sel_def),
                    async_event_notice_ok: !is_legacy(sel_def), legacy: is_legacy(sel_def), cur_def: sel_def,
                    remaining: remaining_ff, ack_wait: state_ff == ST_ACK, param_wait: state_ff == ST_PARAM,
                    opclass: opclass_ff, good: good_ff, check: check_ff, busy: state_ff != ST_IDLE}; // R17 R18 R19

  // Write decode: unmapped or read-only addresses answer SLVERR
  always_comb begin
    if ((awaddr_ff == ADDR_CDB0) || (awaddr_ff == ADDR_CDB1) || (awaddr_ff == ADDR_CDB2)) begin
      wr_hit = 1'b1;
    end else if ((awaddr_ff == ADDR_CTRL) || (awaddr_ff == ADDR_PDATA)) begin
      wr_hit = 1'b1;
    end else if ((awaddr_ff == ADDR_SEL) || (awaddr_ff == ADDR_UA)) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Read decode
  always_comb begin
    rd_hit = 1'b1;
    if (s_axi_araddr == ADDR_CDB0) begin
      rd_word = cdb0_ff;
    end else if (s_axi_araddr == ADDR_CDB1) begin
      rd_word = cdb1_ff;
    end else if (s_axi_araddr == ADDR_CDB2) begin
      rd_word = {16'h0000, cdb2_ff};
    end else if (s_axi_araddr == ADDR_STATUS) begin
      rd_word = status;
    end else if (s_axi_araddr == ADDR_SEL) begin
      rd_word = sel_ff;
    end else if (s_axi_araddr == ADDR_DEF) begin
      rd_word = {25'h000_0000, sel_def};
    end else if (s_axi_araddr == ADDR_UA) begin
      rd_word = {24'h00_0000, ua_ff[{sel_ff.init, LUN_ZERO} +: LUNS]};
    end else begin
      rd_word = ZERO_WORD;
      rd_hit = 1'b0;
    end
  end

  // Storage registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cdb0_ff <= ZERO_WORD;
      cdb1_ff <= ZERO_WORD;
      cdb2_ff <= '0;
      sel_ff <= '0;
    end else begin
      if (wr_cdb0) cdb0_ff <= merge(cdb0_ff, wdata_ff, wstrb_ff);
      if (wr_cdb1) cdb1_ff <= merge(cdb1_ff, wdata_ff, wstrb_ff);
      if (wr_cdb2) cdb2_ff <= 16'(merge({16'h0000, cdb2_ff}, wdata_ff, wstrb_ff));
      if (wr_sel) sel_ff <= odc_sel_t'(merge(sel_ff, wdata_ff, wstrb_ff) & 32'h0000_0377);
    end
  end

  // Write channels: address and data held independently, one response per pair
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= ZERO_WORD;
      wstrb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        wready_ff <= 1'b0;
      end
      if (do_wr) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // Read channels
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= ZERO_WORD;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign nv_save = nv_save_ff;
  assign nv_save_def = nv_save_def_ff;
  assign async_event_notice_en = aen_en_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence seq_start_chg;
    start && !hrst_rise && (cdb.opc == OPC_CHG_DEF);
  endsequence
  sequence seq_commit;
    (state_ff == ST_ACK) ##1 apply;
  endsequence

  AST_OPC_DECODE: assert property (seq_start_chg |=> opclass_ff == OC_CHG) // R1
    else $error("change opcode not decoded");
  AST_INQ_GOOD: assert property (start && !hrst_rise && (cdb.opc == OPC_INQUIRY) |=> good_ff && !check_ff) // R2
    else $error("inquiry not accepted");
  AST_LEN_ZERO: assert property (seq_start_chg ##0 (!def_bad && (cdb.len == '0)) // R7
    |=> (state_ff == ST_ACK) && !check_ff)
    else $error("zero length command did not wait for ack");
  AST_RSVD_CHECK: assert property (seq_start_chg ##0 def_bad |=> check_ff && (state_ff == ST_IDLE)) // R23
    else $error("reserved definition not refused");
  AST_ABORT_KEEP: assert property (abort && !hrst_rise && (state_ff == ST_ACK) // R12
    |=> check_ff && (state_ff == ST_IDLE) && !nv_save_ff)
    else $error("failed command not rolled back");
  AST_SAVE: assert property (seq_commit ##0 cmd_ff.save && (cmd_ff.defp != DEF_KEEP) // R4
    |=> nv_save_ff && (nv_save_def_ff == $past(cmd_ff.defp)))
    else $error("persist flag did not save");
  AST_UA_SET: assert property (apply && (cmd_ff.defp != DEF_KEEP) |=> ua_ff[$past(cmd_idx)]) // R11
    else $error("unit attention not raised");
  AST_KEEP_DEF: assert property (apply && (cmd_ff.defp == DEF_KEEP) // R5
    |=> def_mem_ff[cmd_idx] == $past(def_mem_ff[cmd_idx]))
    else $error("keep value changed the definition");
  AST_INIT_LOAD: assert property (init_pend_ff // R14
    |=> def_mem_ff[0] == (SAVE_IMPL ? $past(nv_saved_def) : DEF_DEFAULT))
    else $error("initial definition not loaded");
  AST_PARAM_COUNT: assert property ((state_ff == ST_PARAM) && (remaining_ff == 8'h01) // R8
    && wr_pdata && !abort && !hrst_rise |=> state_ff == ST_ACK)
    else $error("parameter count wrong");
endmodule : odc_top

//--- sim/odc_init_model.sv
// Initiator-side model that acknowledges the command complete message
`timescale 1ns/100ps
module odc_init_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Request from the bench and bus pin
  input wire logic ack_req,
  output logic cc_ack
);
  logic [2:0] cnt_ff;
  // Hold ACK four cycles so the two-stage synchroniser surely sees it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 3'h0;
    end else if (ack_req) begin
      cnt_ff <= 3'h4;
    end else if (cnt_ff != 3'h0) begin
      cnt_ff <= cnt_ff - 3'h1;
    end
  end
  assign cc_ack = (cnt_ff != 3'h0);
endmodule : odc_init_model

//--- sim/tb.sv
// Testbench of the operating definition command block
`timescale 1ns/100ps
module tb;
  import odc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, ack_req = 1'b0, hrst = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awready, wready, bvalid, arready, rvalid, cc_ack, nv_save, async_event_notice;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [6:0] nv_def;
  logic [7:0] opc [6] = '{8'h39, 8'h18, 8'h12, 8'h03, 8'h1D, 8'h00};
  logic [6:0] rsv [4] = '{7'h04, 7'h3F, 7'h40, 7'h7F};
  int err_count = 0, num_checks = 0, cyc = 0, saves = 0;
  always #4 clk = ~clk;
  odc_top dut (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cc_ack(cc_ack), .bus_hard_rst(hrst), .nv_saved_def(7'h02), .nv_save(nv_save),
    .nv_save_def(nv_def), .async_event_notice_en(async_event_notice));
  odc_init_model model (.clk(clk), .rstn(rstn), .ack_req(ack_req), .cc_ack(cc_ack));
  always @(posedge clk) begin
    if (nv_save === 1'b1) saves <= saves + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic a_ok = 1'b0;
    logic w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge clk);
      if (awready === 1'b1) begin
        a_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask : wr
  // Read and compare the masked word
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    chk(rdata & m, e);
    chk(32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask : rdc
  task automatic cmd(input logic [31:0] b0, input logic [31:0] b2);
    wr(ADDR_CDB0, b0, RESP_OKAY);
    wr(ADDR_CDB2, b2, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
  endtask : cmd
  // Apply lands three edges after the pin rises; ten is ample
  task automatic ack();
    @(posedge clk);
    ack_req <= 1'b1;
    @(posedge clk);
    ack_req <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : ack
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(ADDR_DEF, 32'h7F, 32'h02, RESP_OKAY);
    cmd(32'h0101_0040, ZERO_WORD);
    rdc(ADDR_STATUS, 32'hFFC6, 32'h0080, RESP_OKAY);
    rdc(ADDR_DEF, 32'h7F, 32'h02, RESP_OKAY);
    ack();
    rdc(ADDR_STATUS, 32'h06, 32'h04, RESP_OKAY);
    rdc(ADDR_DEF, 32'h7F, 32'h01, RESP_OKAY);
    chk(32'(async_event_notice), 32'h0);
    chk(32'(nv_def), 32'h01);
    rdc(ADDR_UA, 32'hFF, 32'h01, RESP_OKAY);
    wr(ADDR_UA, 32'h01, RESP_OKAY);
    rdc(ADDR_UA, 32'hFF, 32'h00, RESP_OKAY);
    cmd(32'h0300_0040, ZERO_WORD);
    ack();
    rdc(ADDR_DEF, 32'h7F, 32'h03, RESP_OKAY);
    chk(32'(nv_def), 32'h01);
    chk(32'(async_event_notice), 32'h1);
    foreach (rsv[i]) begin
      cmd({1'b0, rsv[i], 24'h00_0040}, ZERO_WORD);
      rdc(ADDR_STATUS, 32'h06, 32'h02, RESP_OKAY);
    end
    rdc(ADDR_DEF, 32'h7F, 32'h03, RESP_OKAY);
    cmd(32'h0100_0040, 32'h0000_0002);
    rdc(ADDR_STATUS, 32'hFFC0, 32'h0240, RESP_OKAY);
    wr(ADDR_PDATA, 32'h5A, RESP_OKAY);
    wr(ADDR_PDATA, 32'hA5, RESP_OKAY);
    rdc(ADDR_STATUS, 32'hFFC0, 32'h0080, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0100, RESP_OKAY);
    rdc(ADDR_STATUS, 32'h06, 32'h02, RESP_OKAY);
    rdc(ADDR_DEF, 32'h7F, 32'h03, RESP_OKAY);
    foreach (opc[i]) begin
      cmd({24'h00_0000, opc[i]}, ZERO_WORD);
      rdc(ADDR_STATUS, 32'h38, 32'(i + 2) << 3, RESP_OKAY);
    end
    cmd(32'h0001_0040, ZERO_WORD);
    ack();
    chk(32'(nv_def), 32'h03);
    chk(saves, 2);
    wr(ADDR_UA, 32'h01, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0200, RESP_OKAY);
    rdc(ADDR_UA, 32'hFF, 32'h01, RESP_OKAY);
    wr(ADDR_SEL, 32'h0000_0355, RESP_OKAY);
    cmd(32'h0100_0040, ZERO_WORD);
    ack();
    rdc(ADDR_DEF, 32'h7F, 32'h01, RESP_OKAY);
    rdc(ADDR_UA, 32'hFF, 32'hFF, RESP_OKAY);
    hrst <= 1'b1;
    repeat (4) @(posedge clk);
    hrst <= 1'b0;
    rdc(ADDR_DEF, 32'h7F, 32'h02, RESP_OKAY);
    wr(ADDR_DEF, 32'h01, RESP_SLVERR);
    rdc(8'h40, 32'hFFFF_FFFF, ZERO_WORD, RESP_SLVERR);
    finish_test();
  end
endmodule : tb
